// File: bench/board_clear_driver.sv
/*
  Board-side model of the master-clear circuit that drives the reset pin.
  Assumes it shares the sequencer clock and that the line has a pull-up,
  so a released pin reads high.
*/
`timescale 1ns/1ps
`default_nettype none

module board_clear_driver #(
  parameter int SETTLE = 40
) (
  input wire logic clk, // Board clock
  input wire logic start, // Request one low pulse
  input wire logic [7:0] low_cycles, // Length of that pulse
  output logic pin_n // Master-clear line
);
  // Pin held low from power-up until the supply has settled
  int unsigned low_left = SETTLE;

  // Count down the low time; a new request restarts it
  always @(posedge clk) begin
    if (start) begin
      low_left <= {24'h0, low_cycles};
    end else if (low_left != 0) begin
      low_left <= low_left - 1;
    end
  end

  // Pull-up takes the line high once nobody pulls it down
  assign pin_n = (low_left == 0);
endmodule : board_clear_driver

`default_nettype wire

// File: bench/tb_top.sv
/*
  Self-checking bench for the reset sequencer: bus master, cause events
  and a read scoreboard fed by a queue of expected values.
  Assumes the board model drives the master-clear pin and a short delay.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  err_count++; \
  $display("FAIL %0t got %0h want %0h", $time, (got), (exp)); end end

module tb_top;
  localparam int DELAY = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wdt = 1'b0;
  logic core_asleep = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic core_reset;
  logic [7:0] pc_low_byte;
  logic [7:0] core_status;
  logic [7:0] file_select_pointer;
  logic [7:0] pin_direction_control;
  logic [5:0] timer_prescaler_config;
  logic pin_n;
  logic clear_start = 1'b0;
  logic [7:0] clear_len = 8'h00;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] exp_q [$];
  logic [15:0] lfsr_reg = 16'h143D;

  mcu_reset_sequencer #(.RESET_DELAY_CYCLES(DELAY), .LARGE_PROGRAM(1'b1))
  u_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .MASTER_CLEAR_PIN_N(pin_n),
    .WATCHDOG_EXPIRY_SOURCE(wdt), .CORE_ASLEEP(core_asleep),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .CORE_RESET(core_reset),
    .PC_LOW_BYTE(pc_low_byte), .CORE_STATUS(core_status),
    .FILE_SELECT_POINTER(file_select_pointer),
    .PIN_DIRECTION_CONTROL(pin_direction_control),
    .TIMER_PRESCALER_CONFIG(timer_prescaler_config)
  );

  board_clear_driver #(.SETTLE(40)) u_board (
    .clk(sys_clk), .start(clear_start), .low_cycles(clear_len),
    .pin_n(pin_n)
  );

  // Free-running 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run, shared by the main flow and the bus-stall, pin and wait_core timeouts
  task automatic close_out;
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Galois shift register, fixed seed
  function automatic logic [7:0] rnd();
    lfsr_reg = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ 16'hB400) : (lfsr_reg >> 1);
    return lfsr_reg[7:0];
  endfunction : rnd

  // One Avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus_cycle(input logic wr, input logic [5:0] a,
                           input logic [7:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("FAIL %0t bus stalled", $time);
      close_out();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge so a request line is never set twice in one step
    @(posedge sys_clk);
  endtask : bus_cycle

  task automatic bus_read(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_cycle(1'b0, a, 8'h00);
  endtask : bus_read

  // Cycles from the event until the core is released again
  task automatic wait_core(output int n, output logic seen);
    n = 0;
    seen = 1'b0;
    while (n < DELAY + 60) begin
      @(posedge sys_clk);
      n++;
      if (core_reset === 1'b1) begin
        seen = 1'b1;
      end else if (seen) begin
        break;
      end
    end
    if (n >= DELAY + 60) begin
      err_count++;
      $display("FAIL %0t core never released", $time);
      close_out();
    end
  endtask : wait_core

  // Scoreboard: oldest note against each accepted read
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      `CHK(avs_readdata, exp_q.pop_front())
    end
  end

  // Event table: watchdog, asleep, expected expiry flag, sleep flag
  logic [3:0] events [6] = '{4'b1001, 4'b0001, 4'b0110, 4'b0010,
                             4'b1100, 4'b0000};

  initial begin
    logic [3:0] ev;
    logic [7:0] w, s, f, p;
    logic [1:0] flags;
    logic seen;
    int n;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // Power-up loads while the board still holds the pin low
    `CHK(core_status[7:3], 5'b00011)
    `CHK(pc_low_byte, 8'hFF)
    `CHK(pin_direction_control, 8'hFF)
    `CHK(timer_prescaler_config, 6'h3F)
    `CHK(file_select_pointer[7], 1'b1)
    repeat (30) @(posedge sys_clk);
    `CHK(core_reset, 1'b1)
    n = 0;
    while (pin_n !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (pin_n !== 1'b1) begin
      err_count++;
      $display("FAIL %0t pin never released", $time);
      close_out();
    end
    n = 0;
    while (core_reset !== 1'b0 && n < DELAY + 40) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK((n >= DELAY + 1) && (n <= DELAY + 6), 1'b1)
    flags = 2'b11;
    bus_read(6'h00, 32'h0);
    bus_read(6'h30, 32'h0);
    bus_read(6'h2C, 32'h0);
    // Every master-clear and watchdog cause, each after fresh random register contents
    for (int i = 0; i < 6; i++) begin
      ev = events[i];
      w = rnd();
      s = rnd();
      f = rnd();
      p = rnd();
      bus_cycle(1'b1, 6'h20, w);
      bus_cycle(1'b1, 6'h0C, s);
      bus_cycle(1'b1, 6'h10, f);
      bus_cycle(1'b1, 6'h08, p);
      bus_cycle(1'b1, 6'h24, p);
      bus_cycle(1'b1, 6'h28, p);
      bus_read(6'h08, {24'h0, p});
      bus_read(6'h24, {24'h0, p});
      bus_read(6'h28, {26'h0, p[5:0]});
      bus_read(6'h0C, {24'h0, s[7:5], flags, s[2:0]});
      core_asleep <= ev[2];
      if (ev[3]) begin
        wdt <= 1'b1;
        @(posedge sys_clk);
        wdt <= 1'b0;
      end else begin
        clear_len <= 8'h06;
        clear_start <= 1'b1;
        @(posedge sys_clk);
        clear_start <= 1'b0;
      end
      wait_core(n, seen);
      `CHK(seen, 1'b1)
      `CHK((n >= DELAY) && (n <= DELAY + 20), 1'b1)
      core_asleep <= 1'b0;
      flags = ev[1:0];
      `CHK(core_status, {3'h0, flags, s[2:0]})
      `CHK(pc_low_byte, 8'hFF)
      `CHK(pin_direction_control, 8'hFF)
      `CHK(timer_prescaler_config, 6'h3F)
      `CHK(file_select_pointer, {1'b1, f[6:0]})
      bus_read(6'h20, {24'h0, w});
      bus_read(6'h2C, {28'h0, 1'b0, ev[2], ev[3], ~ev[3]});
    end
    `CHK(exp_q.size(), 0)
    close_out();
  end
endmodule : tb_top

`default_nettype wire

// File: src/mcu_reset_map.svh
/*
  Constants of the reset sequencer: register indices, field positions,
  reset values and the reset-delay timing.
  Assumes inclusion by bare name from the sequencer and its package users.
*/
// What this block does
// R1: Accept power-up, master-clear run, master-clear wake, watchdog run, watchdog wake.
// R2: Wake from sleep by master-clear or watchdog performs full reset, no resume.
// R3: Untouched registers power up undefined and keep value on other resets.
// R4: Watchdog-expiry and sleep-entry flags sit at status bits 4 and 3.
// R5: Power-up sets both cause flags to one.
// R6: Master-clear reset while running leaves both cause flags unchanged.
// R7: Master-clear wake sets watchdog-expiry flag, clears sleep-entry flag.
// R8: Watchdog reset while running clears watchdog-expiry, sets sleep-entry flag.
// R9: Watchdog wake from sleep clears both cause flags.
// R10: Status loads 0001 1xxx at power-up, 000q quuu on other resets.
// R11: Every reset sets pc low byte, pin direction and six config bits to ones.
// R12: File-select pointer top bit forced one (2K) or top three bits (smaller).
// R13: Power-up sets reset latch and clears reset timer, holding core.
// R14: Reset timer starts counting only once master-clear pin is high.
// R15: Timer time-out of 18 ms clears reset latch and releases core.
// R16: Board keeps master-clear low until supply stable, then releases high.
// R17: No internal reset when supply falls; no brown-out detection here.
// R18: Core stays in reset as long as the reset timer is active.
// R19: Watchdog time-out restarts reset timer for the full delay.
// R20: Reset timer runs from its own clock, independent of oscillator mode.
// R21: Master-clear synchronised before use; time-out count derived from clock rate.
// R22: Cause and sleep state recorded; new master-clear restarts the timer.
`ifndef MCU_RESET_MAP_SVH
`define MCU_RESET_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_INDIRECT_DATA_PORT 4'h0
`define IDX_TIMER_COUNT 4'h1
`define IDX_PC_LOW_BYTE 4'h2
`define IDX_CORE_STATUS 4'h3
`define IDX_FILE_SELECT_POINTER 4'h4
`define IDX_PORT_A_PINS 4'h5
`define IDX_PORT_B_PINS 4'h6
`define IDX_PORT_C_PINS 4'h7
`define IDX_WORKING_ACCUMULATOR 4'h8
`define IDX_PIN_DIRECTION_CONTROL 4'h9
`define IDX_TIMER_PRESCALER_CONFIG 4'hA
`define IDX_RESET_CAUSE 4'hB

// Status field positions
`define ST_BIT_WATCHDOG_EXPIRY 4
`define ST_BIT_SLEEP_ENTRY 3
`define ST_PAGE_HI 7
`define ST_PAGE_LO 5
`define ST_ALU_HI 2

// Reset values
`define RST_PC_LOW_BYTE 8'hFF
`define RST_PIN_DIRECTION 8'hFF
`define RST_PRESCALER_CFG 6'h3F
`define RST_PAGE_SELECT 3'h0
`define RST_FSR_TOP_LARGE 1'h1
`define RST_FSR_TOP_SMALL 3'h7

// Reset-delay timing
`define RESET_DELAY_MS 18
`define SYS_CLK_KHZ 200000
`define RESET_DELAY_CYCLES (`RESET_DELAY_MS * `SYS_CLK_KHZ)

`endif

// File: src/mcu_reset_pkg.sv
/*
  Types of the reset sequencer: sequencing states and reset causes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mcu_reset_pkg;
  // Gray codes along hold -> count -> run
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN = 2'b11
  } seq_state_type;

  typedef enum logic [1:0] {
    CAUSE_POWER = 2'h0,
    CAUSE_MASTER_CLEAR = 2'h1,
    CAUSE_WATCHDOG = 2'h2
  } reset_cause_type;
endpackage : mcu_reset_pkg

// File: src/mcu_reset_sequencer.sv
/*
  Reset sequencer for a small 8-bit core: power-up latch, reset-delay
  timer, cause flags and the reset loading of the special registers,
  which software reaches over an Avalon-MM slave with waitrequest.
  Assumes all inputs but MASTER_CLEAR_PIN_N are synchronous to SYS_CLK and RESET is the
  power-up reset, synchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcu_reset_map.svh"

module mcu_reset_sequencer #(
  parameter int unsigned RESET_DELAY_CYCLES = `RESET_DELAY_CYCLES,
  parameter bit LARGE_PROGRAM = 1'b1
) (
  input wire logic SYS_CLK, // System clock, 200 MHz
  input wire logic RESET, // Power-up reset, active high
  input wire logic MASTER_CLEAR_PIN_N, // Master-clear pin, low resets
  input wire logic WATCHDOG_EXPIRY_SOURCE, // Watchdog time-out pulse
  input wire logic CORE_ASLEEP, // Core is in sleep mode
  input wire logic [5:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read request
  input wire logic AVS_WRITE, // Write request
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  input wire logic [3:0] AVS_BYTEENABLE, // Byte enables
  output logic [31:0] AVS_READDATA, // Read data
  output logic AVS_WAITREQUEST, // Stall while answer pending
  output logic CORE_RESET, // Core held in reset
  output logic [7:0] PC_LOW_BYTE, // Program counter low byte
  output logic [7:0] CORE_STATUS, // Status register
  output logic [7:0] FILE_SELECT_POINTER, // File-select pointer
  output logic [7:0] PIN_DIRECTION_CONTROL, // Pin direction
  output logic [5:0] TIMER_PRESCALER_CONFIG // Timer/prescaler configuration
);

  localparam logic [21:0] DELAY_LAST = 22'(RESET_DELAY_CYCLES - 1);

  // Master-clear synchroniser; first stage only feeds the second
  logic master_clear_pin_s1_reg;
  logic master_clear_pin_s2_reg;
  logic master_clear_pin_s3_reg;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      master_clear_pin_s1_reg <= 1'b0;
      master_clear_pin_s2_reg <= 1'b0;
      master_clear_pin_s3_reg <= 1'b0;
    end else begin
      master_clear_pin_s1_reg <= MASTER_CLEAR_PIN_N; // R21
      master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
      master_clear_pin_s3_reg <= master_clear_pin_s2_reg;
    end
  end

  // Reset events; master-clear wins over a watchdog in the same cycle
  wire master_clear_pin_high = master_clear_pin_s2_reg;
  wire master_clear_pin_fall = master_clear_pin_s3_reg & ~master_clear_pin_s2_reg; // R1
  wire wdt_evt = WATCHDOG_EXPIRY_SOURCE & master_clear_pin_s2_reg & master_clear_pin_s3_reg; // R1
  wire load_evt = master_clear_pin_fall | wdt_evt; // R2

  // Sequencer state and reset-delay timer
  mcu_reset_pkg::seq_state_type state_reg;
  mcu_reset_pkg::seq_state_type state_next;
  logic [21:0] count_reg;
  logic [21:0] count_next;
  logic core_reset_reg;

  // Timer runs on SYS_CLK, never on the oscillator-mode clock
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      mcu_reset_pkg::ST_HOLD: begin
        count_next = 22'h0;
        if (master_clear_pin_high) begin
          state_next = mcu_reset_pkg::ST_COUNT; // R14 R16
        end
      end
      mcu_reset_pkg::ST_COUNT: begin
        if (!master_clear_pin_high) begin
          state_next = mcu_reset_pkg::ST_HOLD; // R22
          count_next = 22'h0;
        end else if (wdt_evt) begin
          count_next = 22'h0; // R19
        end else if (count_reg == DELAY_LAST) begin
          state_next = mcu_reset_pkg::ST_RUN; // R15
          count_next = 22'h0;
        end else begin
          count_next = count_reg + 22'h1; // R20
        end
      end
      mcu_reset_pkg::ST_RUN: begin
        if (!master_clear_pin_high) begin
          state_next = mcu_reset_pkg::ST_HOLD;
        end else if (wdt_evt) begin
          state_next = mcu_reset_pkg::ST_COUNT; // R19
        end
      end
      default: begin
        state_next = mcu_reset_pkg::ST_HOLD;
        count_next = 22'h0;
      end
    endcase
  end

  // Supply falling is not watched; only RESET, the pin and the watchdog act
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= mcu_reset_pkg::ST_HOLD; // R13 R17
      count_reg <= 22'h0; // R13
      core_reset_reg <= 1'b1; // R13
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      core_reset_reg <= (state_next != mcu_reset_pkg::ST_RUN); // R18
    end
  end

  // Recorded cause and sleep state of the last reset
  mcu_reset_pkg::reset_cause_type cause_reg;
  logic asleep_reg;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cause_reg <= mcu_reset_pkg::CAUSE_POWER;
      asleep_reg <= 1'b0;
    end else if (master_clear_pin_fall) begin
      cause_reg <= mcu_reset_pkg::CAUSE_MASTER_CLEAR; // R22
      asleep_reg <= CORE_ASLEEP;
    end else if (wdt_evt) begin
      cause_reg <= mcu_reset_pkg::CAUSE_WATCHDOG; // R22
      asleep_reg <= CORE_ASLEEP;
    end
  end

  // Avalon slave: one wait state, so every answer is registered
  logic ack_reg;
  logic [31:0] rdata_reg;
  wire access = AVS_READ | AVS_WRITE;
  wire [3:0] index = AVS_ADDRESS[5:2];
  wire wr_take = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
  wire [7:0] wbyte = AVS_WRITEDATA[7:0];

  assign AVS_WAITREQUEST = access & ~ack_reg;
  assign AVS_READDATA = rdata_reg;

  function automatic logic hit(input logic [3:0] idx, input logic [3:0] sel);
    hit = wr_take && (idx == sel);
  endfunction : hit

  // Special registers
  logic [7:0] pcl_reg;
  logic [7:0] status_reg;
  logic [7:0] fsr_reg;
  logic [7:0] pin_direction_control_reg;
  logic [5:0] option_reg;
  logic [7:0] w_reg;
  logic [7:0] tmr_reg;
  logic [3:0] port_a_pins_reg;
  logic [7:0] port_b_pins_reg;
  logic [7:0] port_c_pins_reg;

  // Cause flags per event, from the run or sleep state at that moment
  logic [1:0] flags_next;
  always_comb begin
    flags_next = status_reg[`ST_BIT_WATCHDOG_EXPIRY:`ST_BIT_SLEEP_ENTRY];
    if (master_clear_pin_fall && CORE_ASLEEP) begin
      flags_next = 2'h2; // R7
    end else if (master_clear_pin_fall) begin
      flags_next = status_reg[`ST_BIT_WATCHDOG_EXPIRY:`ST_BIT_SLEEP_ENTRY]; // R6
    end else if (wdt_evt && CORE_ASLEEP) begin
      flags_next = 2'h0; // R9
    end else if (wdt_evt) begin
      flags_next = 2'h1; // R8
    end
  end

  // Forced-to-one registers; a reset load beats a software write
  always_ff @(posedge SYS_CLK) begin
    if (RESET || load_evt) begin
      pcl_reg <= `RST_PC_LOW_BYTE; // R11
      pin_direction_control_reg <= `RST_PIN_DIRECTION; // R11
      option_reg <= `RST_PRESCALER_CFG; // R11
    end else begin
      if (hit(index, `IDX_PC_LOW_BYTE)) begin
        pcl_reg <= wbyte;
      end
      if (hit(index, `IDX_PIN_DIRECTION_CONTROL)) begin
        pin_direction_control_reg <= wbyte;
      end
      if (hit(index, `IDX_TIMER_PRESCALER_CONFIG)) begin
        option_reg <= wbyte[5:0];
      end
    end
  end

  // Status: page bits and cause flags reset; low ALU bits never reset
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      status_reg[`ST_PAGE_HI:`ST_PAGE_LO] <= `RST_PAGE_SELECT; // R10
      status_reg[`ST_BIT_WATCHDOG_EXPIRY:`ST_BIT_SLEEP_ENTRY] <= 2'h3; // R5
    end else if (load_evt) begin
      status_reg[`ST_PAGE_HI:`ST_PAGE_LO] <= `RST_PAGE_SELECT; // R10
      status_reg[`ST_BIT_WATCHDOG_EXPIRY:`ST_BIT_SLEEP_ENTRY] <= flags_next; // R4
    end else if (hit(index, `IDX_CORE_STATUS)) begin
      // Cause flags stay read-only to software
      status_reg[`ST_PAGE_HI:`ST_PAGE_LO] <= wbyte[`ST_PAGE_HI:`ST_PAGE_LO];
    end
    // Low ALU bits: undefined at power-up, kept by every other reset
    if (hit(index, `IDX_CORE_STATUS)) begin
      status_reg[`ST_ALU_HI:0] <= wbyte[`ST_ALU_HI:0]; // R3 R10
    end
  end

  // Pointer: top bits forced per program-space variant
  always_ff @(posedge SYS_CLK) begin
    if (RESET || load_evt) begin
      if (LARGE_PROGRAM) begin
        fsr_reg[7] <= `RST_FSR_TOP_LARGE; // R12
      end else begin
        fsr_reg[7:5] <= `RST_FSR_TOP_SMALL; // R12
      end
    end else if (hit(index, `IDX_FILE_SELECT_POINTER)) begin
      fsr_reg[7:5] <= wbyte[7:5];
    end
    // Low pointer bits are never reset, only written
    if (hit(index, `IDX_FILE_SELECT_POINTER)) begin
      fsr_reg[4:0] <= wbyte[4:0]; // R3
    end
  end

  // Accumulator, timer count and port latches have no reset at all
  always_ff @(posedge SYS_CLK) begin
    if (hit(index, `IDX_WORKING_ACCUMULATOR)) begin
      w_reg <= wbyte; // R3
    end
    if (hit(index, `IDX_TIMER_COUNT)) begin
      tmr_reg <= wbyte; // R3
    end
    if (hit(index, `IDX_PORT_A_PINS)) begin
      port_a_pins_reg <= wbyte[3:0]; // R3
    end
    if (hit(index, `IDX_PORT_B_PINS)) begin
      port_b_pins_reg <= wbyte; // R3
    end
    if (hit(index, `IDX_PORT_C_PINS)) begin
      port_c_pins_reg <= wbyte; // R3
    end
  end

  // Read multiplexer; unmapped and indirect reads return zero
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    unique case (index)
      `IDX_TIMER_COUNT: rmux = tmr_reg;
      `IDX_PC_LOW_BYTE: rmux = pcl_reg;
      `IDX_CORE_STATUS: rmux = status_reg;
      `IDX_FILE_SELECT_POINTER: rmux = fsr_reg;
      `IDX_PORT_A_PINS: rmux = {4'h0, port_a_pins_reg};
      `IDX_PORT_B_PINS: rmux = port_b_pins_reg;
      `IDX_PORT_C_PINS: rmux = port_c_pins_reg;
      `IDX_WORKING_ACCUMULATOR: rmux = w_reg;
      `IDX_PIN_DIRECTION_CONTROL: rmux = pin_direction_control_reg;
      `IDX_TIMER_PRESCALER_CONFIG: rmux = {2'h0, option_reg};
      `IDX_RESET_CAUSE: rmux = {4'h0, core_reset_reg, asleep_reg, cause_reg};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (AVS_READ && !ack_reg) begin
        rdata_reg <= {24'h0, rmux};
      end
    end
  end

  assign CORE_RESET = core_reset_reg;
  assign PC_LOW_BYTE = pcl_reg;
  assign CORE_STATUS = status_reg;
  assign FILE_SELECT_POINTER = fsr_reg;
  assign PIN_DIRECTION_CONTROL = pin_direction_control_reg;
  assign TIMER_PRESCALER_CONFIG = option_reg;

  // Checks of the sequencing and the reset loading
  property p_hold_reset;
    @(posedge SYS_CLK) disable iff (RESET)
      state_reg != mcu_reset_pkg::ST_RUN |-> CORE_RESET;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("core released early"); // R18

  property p_power_flags;
    @(posedge SYS_CLK) $fell(RESET) |->
      status_reg[4:3] == 2'h3 && CORE_RESET && count_reg == 22'h0;
  endproperty
  a_power_flags: assert property (p_power_flags) else $error("power-up load wrong"); // R5

  property p_master_clear_pin_run;
    @(posedge SYS_CLK) disable iff (RESET)
      master_clear_pin_fall && !CORE_ASLEEP |=> status_reg[4:3] == $past(status_reg[4:3]);
  endproperty
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("flags changed"); // R6

  property p_master_clear_pin_wake;
    @(posedge SYS_CLK) disable iff (RESET)
      master_clear_pin_fall && CORE_ASLEEP |=> status_reg[4:3] == 2'h2;
  endproperty
  a_master_clear_pin_wake: assert property (p_master_clear_pin_wake) else $error("wake flags wrong"); // R7

  property p_wdt_run;
    @(posedge SYS_CLK) disable iff (RESET)
      wdt_evt && !master_clear_pin_fall && !CORE_ASLEEP |=> status_reg[4:3] == 2'h1;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog flags wrong"); // R8

  property p_wdt_wake;
    @(posedge SYS_CLK) disable iff (RESET)
      wdt_evt && !master_clear_pin_fall && CORE_ASLEEP |=> status_reg[4:3] == 2'h0;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("wdt wake flags"); // R9

  property p_load_ones;
    @(posedge SYS_CLK) disable iff (RESET)
      load_evt |=> pcl_reg == 8'hFF && pin_direction_control_reg == 8'hFF &&
        option_reg == 6'h3F && status_reg[7:5] == 3'h0 && fsr_reg[7];
  endproperty
  a_load_ones: assert property (p_load_ones) else $error("reset load wrong"); // R11

  property p_wait_low;
    @(posedge SYS_CLK) disable iff (RESET)
      !master_clear_pin_high |=> count_reg == 22'h0 ##1 count_reg == 22'h0 || master_clear_pin_high;
  endproperty
  a_wait_low: assert property (p_wait_low) else $error("timer ran low"); // R14

  property p_release;
    @(posedge SYS_CLK) disable iff (RESET)
      state_reg == mcu_reset_pkg::ST_COUNT && count_reg == DELAY_LAST &&
        master_clear_pin_high && !wdt_evt |=> !CORE_RESET;
  endproperty
  a_release: assert property (p_release) else $error("no release"); // R15

  property p_wdt_restart;
    @(posedge SYS_CLK) disable iff (RESET)
      wdt_evt |=> CORE_RESET && count_reg == 22'h0;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) else $error("no restart"); // R19

  property p_one_wait;
    @(posedge SYS_CLK) disable iff (RESET)
      $rose(access) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bad wait state");

  property p_cov_release;
    @(posedge SYS_CLK) disable iff (RESET) $fell(CORE_RESET);
  endproperty
  c_cov_release: cover property (p_cov_release);

  property p_cov_wake;
    @(posedge SYS_CLK) disable iff (RESET) wdt_evt && CORE_ASLEEP;
  endproperty
  c_cov_wake: cover property (p_cov_wake);

  property p_cov_master_clear_pin;
    @(posedge SYS_CLK) disable iff (RESET) master_clear_pin_fall && !CORE_RESET;
  endproperty
  c_cov_master_clear_pin: cover property (p_cov_master_clear_pin);

endmodule : mcu_reset_sequencer
`default_nettype wire
